// ---- flc_params.svh ----
// Register offsets, field positions, reset values and widths for the fan table entry compare
`ifndef FLC_PARAMS_SVH
`define FLC_PARAMS_SVH
`define FLC_ADDR_W 8
`define FLC_OFS_TEMP_OFFSET 8'h4e
`define FLC_OFS_HYST 8'h4f
`define FLC_OFS_E1_TEMP 8'h50
`define FLC_OFS_E1_DUTY 8'h51
`define FLC_TEMP_OFFSET_W 6
`define FLC_HYST_W 5
`define FLC_RST_TEMP_OFFSET 6'h00
`define FLC_RST_HYST 5'h04
`define FLC_RST_E1_TEMP 8'h7f
`define FLC_RST_E1_DUTY 8'h3f
`define FLC_LIMIT_MSB_BIT 7
`define FLC_DUTY_LOW_W 6
`endif

// ---- flc_pkg.sv ----
// Types shared by the fan table entry compare block
package flc_pkg;
    // Comparator state, one-hot
    typedef enum logic [1:0]
    {
        FLC_IDLE = 2'b01,
        FLC_ACTIVE = 2'b10
    } flc_state_t;
endpackage

// ---- flc_lut_entry.sv ----
// Fan table offset, hysteresis, first entry registers and the entry comparator
`timescale 1ns/1ps
`default_nettype none
`include "flc_params.svh"
// Notes on behaviour
// - Add 6-bit unsigned offset to every limit
// - Effective limits may exceed 127, offset to 63
// - Hysteresis bits 7:5 ignore writes, read zero
// - 5-bit hysteresis, 1 degree steps, reset 4
// - Low temp resolution forces limit bit 7 zero
// - High resolution adds half-degree limit bit
// - Above entry limit, drive entry duty value
// - Compare 9 reading bits high, 8 low
// - Entries are positive, sign assumed zero
// - Low duty mode forces extended bits zero
// - Extended duty only at 22.5 kHz selection
// - Low six bits give duty, reset all ones
// - Table starts 0x50, temperature then duty
// - Entries writable only while program bit set
module flc_lut_entry
#(
    // Field widths, fixed by the read-back packing below
    parameter int unsigned OFFSET_W = `FLC_TEMP_OFFSET_W,
    parameter int unsigned HYST_W = `FLC_HYST_W
)
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [7:0] i_addr,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    input wire logic i_rd,
    input wire logic i_pwm_program,
    input wire logic i_temp_hires,
    input wire logic i_duty_hires,
    input wire logic i_freq_22k5,
    input wire logic [10:0] i_remote_temp,
    output logic [7:0] o_rdata,
    output logic [7:0] o_pwm_value,
    output logic o_entry1_active
);
    // Read data register
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    // Stored register fields
    logic [OFFSET_W-1:0] table_temp_offset_q;
    logic [OFFSET_W-1:0] table_temp_offset_d;
    logic [HYST_W-1:0] table_hysteresis_q;
    logic [HYST_W-1:0] table_hysteresis_d;
    logic entry1_limit_msb_q;
    logic entry1_limit_msb_d;
    logic [6:0] entry1_limit_low_q;
    logic [6:0] entry1_limit_low_d;
    logic [1:0] entry1_duty_ext_q;
    logic [1:0] entry1_duty_ext_d;
    logic [`FLC_DUTY_LOW_W-1:0] entry1_duty_low_q;
    logic [`FLC_DUTY_LOW_W-1:0] entry1_duty_low_d;
    // Comparator state and output registers
    flc_pkg::flc_state_t state_q;
    flc_pkg::flc_state_t state_d;
    logic [7:0] pwm_q;
    logic [7:0] pwm_d;
    // Remote reading synchroniser, from the sensing domain
    logic [10:0] temp_meta_q;
    logic [10:0] temp_sync_q;
    // Mode pins synchronised too
    logic [3:0] mode_meta_q;
    logic [3:0] mode_sync_q;
    // Derived comparison values, half-degree units, 10 bits
    logic [9:0] limit_half;
    logic [9:0] release_half;
    logic [9:0] reading_half;
    logic prog_s;
    logic thi_s;
    logic dhi_s;
    logic f22_s;
    // Reading as it stood one cycle ago, and the accepted copy
    logic [10:0] temp_prev_q;
    logic [10:0] temp_use_q;
    logic [10:0] temp_use_d;
    // Active flag in its own flop so the pin comes straight from it
    logic active_q;
    logic active_d;
    // Reset images of the two entry bytes, split into fields below
    localparam logic [7:0] RST_E1_TEMP = `FLC_RST_E1_TEMP;
    localparam logic [7:0] RST_E1_DUTY = `FLC_RST_E1_DUTY;

    // Read packing and the limit adder assume these widths;
    // anything else is refused at elaboration
    if (OFFSET_W != `FLC_TEMP_OFFSET_W || HYST_W != `FLC_HYST_W)
    begin
        $error("flc_lut_entry: unsupported field width");
    end

    // Limit in half degrees plus offset, entries always positive
    function automatic logic [9:0] eff_limit(input logic msb, input logic [6:0] low,
                                             input logic hires,
                                             input logic [5:0] ofs);
        logic [9:0] base;
        base = 10'h000;
        base = {2'b00, low, 1'b0};
        if (hires)
            base = {2'b00, low, msb};
        eff_limit = base + {3'b000, ofs, 1'b0};
    endfunction

    // Two-flop synchronisers for external inputs
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            temp_meta_q <= 11'h000;
            temp_sync_q <= 11'h000;
            mode_meta_q <= 4'h0;
            mode_sync_q <= 4'h0;
            temp_prev_q <= 11'h000;
            temp_use_q <= 11'h000;
        end
        else
        begin
            temp_meta_q <= i_remote_temp;
            temp_sync_q <= temp_meta_q;
            mode_meta_q <= {i_pwm_program, i_temp_hires, i_duty_hires, i_freq_22k5};
            mode_sync_q <= mode_meta_q;
            // Previous copy feeds the agreement test
            temp_prev_q <= temp_sync_q;
            temp_use_q <= temp_use_d;
        end
    end

    // Accept a reading only once it has stood two cycles; the word's bits
    // may cross at different edges, so a torn value is never compared
    always_comb
    begin
        temp_use_d = temp_use_q;
        if (temp_sync_q == temp_prev_q)
            temp_use_d = temp_sync_q;
    end

    assign prog_s = mode_sync_q[3];
    assign thi_s = mode_sync_q[2];
    assign dhi_s = mode_sync_q[1];
    assign f22_s = mode_sync_q[0];

    // Reading is unsigned, 1/8 degree LSB; take integer and half bits
    always_comb
    begin
        reading_half = {1'b0, temp_use_q[10:3], temp_use_q[2]};
        if (!thi_s)
            reading_half = {1'b0, temp_use_q[10:3], 1'b0};
    end

    // Effective limit and release point
    always_comb
    begin
        limit_half = eff_limit(entry1_limit_msb_q, entry1_limit_low_q, thi_s,
                               table_temp_offset_q);
        if (limit_half > {4'h0, table_hysteresis_q, 1'b0})
            release_half = limit_half - {4'h0, table_hysteresis_q, 1'b0};
        else
            release_half = 10'h000;
    end

    // Register write decode and read mux
    always_comb
    begin
        table_temp_offset_d = table_temp_offset_q;
        table_hysteresis_d = table_hysteresis_q;
        entry1_limit_msb_d = entry1_limit_msb_q;
        entry1_limit_low_d = entry1_limit_low_q;
        entry1_duty_ext_d = entry1_duty_ext_q;
        entry1_duty_low_d = entry1_duty_low_q;
        rdata_d = rdata_q;
        if (i_wr)
        begin
            case (i_addr)
                `FLC_OFS_TEMP_OFFSET:
                    table_temp_offset_d = i_wdata[5:0];
                `FLC_OFS_HYST:
                    table_hysteresis_d = i_wdata[4:0];
                `FLC_OFS_E1_TEMP:
                begin
                    if (prog_s)
                    begin
                        entry1_limit_msb_d = i_wdata[`FLC_LIMIT_MSB_BIT];
                        entry1_limit_low_d = i_wdata[6:0];
                    end
                end
                `FLC_OFS_E1_DUTY:
                begin
                    if (prog_s)
                    begin
                        entry1_duty_ext_d = i_wdata[7:6];
                        entry1_duty_low_d = i_wdata[5:0];
                    end
                end
                default:
                begin
                end
            endcase
        end
        if (i_rd)
        begin
            case (i_addr)
                `FLC_OFS_TEMP_OFFSET:
                    rdata_d = {2'b00, table_temp_offset_q};
                `FLC_OFS_HYST:
                    rdata_d = {3'b000, table_hysteresis_q};
                `FLC_OFS_E1_TEMP:
                    rdata_d = {entry1_limit_msb_q & thi_s, entry1_limit_low_q};
                `FLC_OFS_E1_DUTY:
                    rdata_d = {entry1_duty_ext_q & {2{dhi_s & f22_s}}, entry1_duty_low_q};
                default:
                    rdata_d = 8'h00;
            endcase
        end
    end

    // Comparator state machine and PWM choice
    always_comb
    begin
        state_d = state_q;
        pwm_d = 8'h00;
        active_d = 1'b0;
        case (state_q)
            flc_pkg::FLC_IDLE:
            begin
                if (reading_half > limit_half)
                    state_d = flc_pkg::FLC_ACTIVE;
            end
            flc_pkg::FLC_ACTIVE:
            begin
                if (reading_half < release_half)
                    state_d = flc_pkg::FLC_IDLE;
            end
            default:
                state_d = flc_pkg::FLC_IDLE;
        endcase
        // only entry here, so it is highest
        if (state_d == flc_pkg::FLC_ACTIVE)
        begin
            active_d = 1'b1;
            pwm_d = {2'b00, entry1_duty_low_q};
            if (dhi_s && f22_s)
                pwm_d = {entry1_duty_ext_q, entry1_duty_low_q};
        end
    end

    // Register everything
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            table_temp_offset_q <= `FLC_RST_TEMP_OFFSET;
            table_hysteresis_q <= `FLC_RST_HYST;
            // Entry fields cut from the reset images
            entry1_limit_msb_q <= RST_E1_TEMP[`FLC_LIMIT_MSB_BIT];
            entry1_limit_low_q <= RST_E1_TEMP[6:0];
            entry1_duty_ext_q <= RST_E1_DUTY[7:6];
            entry1_duty_low_q <= RST_E1_DUTY[`FLC_DUTY_LOW_W-1:0];
            rdata_q <= 8'h00;
            state_q <= flc_pkg::FLC_IDLE;
            pwm_q <= 8'h00;
            active_q <= 1'b0;
        end
        else
        begin
            table_temp_offset_q <= table_temp_offset_d;
            table_hysteresis_q <= table_hysteresis_d;
            entry1_limit_msb_q <= entry1_limit_msb_d;
            entry1_limit_low_q <= entry1_limit_low_d;
            entry1_duty_ext_q <= entry1_duty_ext_d;
            entry1_duty_low_q <= entry1_duty_low_d;
            rdata_q <= rdata_d;
            state_q <= state_d;
            pwm_q <= pwm_d;
            active_q <= active_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_pwm_value = pwm_q;
    assign o_entry1_active = active_q;
endmodule
`default_nettype wire

// ---- flc_lut_entry_assertions.sv ----
// Port checker for the fan table entry compare
`timescale 1ns/1ps
`default_nettype none
module flc_lut_entry_chk
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [7:0] i_addr,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    input wire logic i_rd,
    input wire logic i_pwm_program,
    input wire logic i_temp_hires,
    input wire logic i_duty_hires,
    input wire logic i_freq_22k5,
    input wire logic [10:0] i_remote_temp,
    input wire logic [7:0] o_rdata,
    input wire logic [7:0] o_pwm_value,
    input wire logic o_entry1_active
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);
    idle_duty_a: assert property
        (!o_entry1_active |-> o_pwm_value == 8'h00) else $error("duty while idle");
    read_hold_a: assert property
        (!$past(i_rd) |-> $stable(o_rdata)) else $error("read data moved");
    offset_top_a: assert property
        ($past(i_rd) && $past(i_addr) == 8'h4e |-> o_rdata[7:6] == 2'b00) else $error("offset top");
    hyst_top_a: assert property
        ($past(i_rd) && $past(i_addr) == 8'h4f |-> o_rdata[7:5] == 3'b000) else $error("hyst top");
    unmapped_zero_a: assert property
        ($past(i_rd) && !($past(i_addr) inside {[8'h4e:8'h51]}) |-> o_rdata == 8'h00)
        else $error("unmapped read");
    limit_msb_a: assert property
        ((!i_temp_hires)[*5] ##0 ($past(i_rd) && $past(i_addr) == 8'h50) |-> !o_rdata[7])
        else $error("limit msb set");
    duty_ext_a: assert property
        ((!i_duty_hires)[*4] |-> o_pwm_value[7:6] == 2'b00) else $error("duty ext set");
    cold_idle_a: assert property
        ((i_remote_temp == 11'h000)[*5] |-> !$rose(o_entry1_active)) else $error("cold trip");
    hot_trip_a: assert property
        ((i_remote_temp == 11'h7ff)[*6] |-> o_entry1_active) else $error("hot no trip");
endmodule
bind flc_lut_entry flc_lut_entry_chk flc_lut_entry_chk_inst (.i_clock, .i_rst_n, .i_addr,
    .i_wr, .i_wdata, .i_rd, .i_pwm_program, .i_temp_hires, .i_duty_hires, .i_freq_22k5,
    .i_remote_temp, .o_rdata, .o_pwm_value, .o_entry1_active);
`default_nettype wire

// ---- flc_lut_entry_tb.sv ----
// Self-checking bench for the fan table entry compare
`timescale 1ns/1ps
`default_nettype none
module flc_lut_entry_tb;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, prog = 0, th = 0, dh = 0, fr = 0;
    logic rdp = 0, pk = 0, pkp = 0, act;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdata, pwm;
    logic [10:0] temp = 11'h000;
    // Model of 0x50, 0x51, 0x4e, 0x4f by low address bits
    logic [7:0] m [4] = '{8'h7f, 8'h3f, 8'h00, 8'h04};
    logic [8:0] q [$];
    logic [8:0] qp [$];
    logic [10:0] tv [9] = '{11'h5f4, 11'h5f8, 11'h4fc, 11'h4fb, 11'h5f7, 11'h5f8, 11'h4ff,
        11'h4f7, 11'h7ff};
    logic [8:0] pv [9] = '{9'h000, 9'h1e5, 9'h1e5, 9'h000, 9'h000, 9'h125, 9'h125, 9'h000,
        9'h125};
    integer err_count = 0, tests_run = 0, seed = 32'h6dab, i, j;
    flc_lut_entry flc_lut_entry_inst (.i_clock(clk), .i_rst_n(rst_n), .i_addr(addr),
        .i_wr(wr), .i_wdata(wd), .i_rd(rd), .i_pwm_program(prog), .i_temp_hires(th),
        .i_duty_hires(dh), .i_freq_22k5(fr), .i_remote_temp(temp), .o_rdata(rdata),
        .o_pwm_value(pwm), .o_entry1_active(act));
    initial forever #4 clk = ~clk;
    task chk(input logic [8:0] seen, input logic [8:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task finish_test;
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge clk);
    endtask
    // Write pulse, then a gap so the strobe never toggles twice at once
    task wrt(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wd = d;
        wr = 1;
        cyc(1);
        wr = 0;
        if (a inside {8'h4e, 8'h4f} || (prog && a inside {8'h50, 8'h51}))
            m[a[1:0]] = d & (a == 8'h4e ? 8'h3f : a == 8'h4f ? 8'h1f : 8'hff);
        cyc(1);
    endtask
    // Read-back masks depend on the settled mode pins
    function automatic logic [7:0] ex(input logic [7:0] a);
        if (a inside {8'h4e, 8'h4f})
            return m[a[1:0]];
        if (a == 8'h50)
            return m[0] & {th, 7'h7f};
        if (a == 8'h51)
            return m[1] & {{2{dh & fr}}, 6'h3f};
        return 8'h00;
    endfunction
    task rdc(input logic [7:0] a);
        addr = a;
        rd = 1;
        q.push_back({1'b0, ex(a)});
        cyc(1);
        rd = 0;
        cyc(1);
    endtask
    task look(input logic [8:0] e);
        qp.push_back(e);
        pk = 1;
        cyc(1);
        pk = 0;
        cyc(1);
    endtask
    // Monitor: results land at the edge after the request
    always @(posedge clk)
    begin
        rdp <= rd;
        pkp <= pk;
    end
    always @(negedge clk)
    begin
        if (rdp)
            chk({1'b0, rdata}, q.pop_front());
        if (pkp)
            chk({act, pwm}, qp.pop_front());
    end
    initial
    begin
        #50000;
        err_count++;
        finish_test;
    end
    initial
    begin
        cyc(6);
        rst_n = 1;
        cyc(3);
        // Every mode and program setting, random data, unmapped neighbours
        for (i = 0; i < 16; i++)
        begin
            {prog, th, dh, fr} = i[3:0];
            cyc(4);
            for (j = 0; j < 6; j++)
                rdc(8'h4d + j[7:0]);
            for (j = 0; j < 6; j++)
                wrt(8'h4d + j[7:0], 8'($random(seed)));
        end
        // Largest offset and hysteresis, limit 127.5, then threshold walk
        {prog, th, dh, fr} = 4'hf;
        cyc(4);
        wrt(8'h4e, 8'hff);
        wrt(8'h4f, 8'hff);
        wrt(8'h50, 8'hff);
        wrt(8'h51, 8'he5);
        for (i = 0; i < 9; i++)
        begin
            if (i == 4)
                {th, fr} = 2'b00;
            cyc(4);
            temp = tv[i];
            cyc(5);
            look(pv[i]);
        end
        // Mid-run reset: fields back to reset images, trip found again
        rst_n = 0;
        cyc(6);
        rst_n = 1;
        m = '{8'h7f, 8'h3f, 8'h00, 8'h04};
        look(9'h000);
        rdc(8'h4f);
        rdc(8'h51);
        cyc(4);
        look(9'h13f);
        cyc(3);
        finish_test;
    end
endmodule
`default_nettype wire
